// ### rtl/qdlc_defines.vh
// Purpose: Constants for the quad DAC load / clear control block
// Assumes: 24-bit serial frames, four channels of 16-bit codes
// Notes:   Included by qdlc_top.v only
`ifndef QDLC_DEFINES_VH
`define QDLC_DEFINES_VH

// ==========================================================
// Frame layout
// ==========================================================
`define QDLC_FRAME_BITS   24
`define QDLC_CODE_BITS    16
`define QDLC_CNT_BITS     5
`define QDLC_RD_BIT       23
`define QDLC_SEL_HI       22
`define QDLC_SEL_LO       20
`define QDLC_CH_HI        17
`define QDLC_CH_LO        16
`define QDLC_HDR_LO       16

// ==========================================================
// Target selects and control bits
// ==========================================================
`define QDLC_SEL_CODE     3'h0
`define QDLC_SEL_CTRL     3'h1
`define QDLC_CTRL_MID_BIT 0
`define QDLC_CTRL_BIP_BIT 1

// ==========================================================
// Codes
// ==========================================================
`define QDLC_CODE_ZERO    16'h0000
`define QDLC_CODE_MSB     16'h8000

`endif

// ### rtl/qdlc_top.v
// Purpose: Input / DAC register update, clear and serial output control
// Assumes: Serial clock well below half of core_clk_i; pins are async
// Notes:   Frame word and control bit layout are local to this block
`include "qdlc_defines.vh"
`default_nettype none

module qdlc_top
#(
	parameter CH_N = 4
)
(
	// Clock and reset
	input  wire                   core_clk_i,
	input  wire                   rst_b_i,
	// Serial link pins
	input  wire                   sclk_i,
	input  wire                   sync_n_i,
	input  wire                   serial_in_i,
	output reg                    serial_out_o,
	// Update, clear and coding pins
	input  wire                   load_strobe_n_i,
	input  wire                   clear_n_i,
	input  wire                   coding_select_i,
	// Codes to the converters, straight binary
	output reg  [CH_N*16-1:0]     dac_code_o
);

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	reg  [5:0]  meta_q;            // First stage, read by second only
	reg  [5:0]  sync_q;            // Second stage, safe to use
	reg  [1:0]  prev_q;            // Last sclk / sync_n for edges
	reg         ld_prev_q;         // Last load strobe for its edge

	wire sclk_s   = sync_q[0];     // Serial clock
	wire frame_n  = sync_q[1];     // Frame sync, active low
	wire serial_in_s   = sync_q[2];     // Serial data in
	wire ld_n_s   = sync_q[3];     // Load strobe, active low
	wire clr_n_s  = sync_q[4];     // Clear, active low
	wire bin_s    = sync_q[5];     // High: offset binary

	// Two flops per pin before any logic looks at it
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= 6'h3b;
			sync_q <= 6'h3b;
		end
		else
		begin
			meta_q <= {coding_select_i, clear_n_i, load_strobe_n_i,
				serial_in_i, sync_n_i, sclk_i};
			sync_q <= meta_q;
		end
	end

	// ==========================================================
	// Edge detection
	// ==========================================================
	wire sclk_fall = prev_q[0] & ~sclk_s;
	wire sclk_rise = ~prev_q[0] & sclk_s;
	wire fr_start  = prev_q[1] & ~frame_n;
	wire fr_end    = ~prev_q[1] & frame_n;
	wire ld_fall   = ld_prev_q & ~ld_n_s;

	// Remember last levels
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			prev_q    <= 2'h3;
			ld_prev_q <= 1'b1;
		end
		else
		begin
			prev_q    <= sync_q[1:0];
			ld_prev_q <= ld_n_s;
		end
	end

	// ==========================================================
	// Shift register and bit counter
	// ==========================================================
	reg  [23:0] sreg_q;            // Serial shift register
	reg  [4:0]  cnt_q;             // Bits taken this frame
	reg         rd_pend_q;         // Last frame asked for readback
	reg  [7:0]  rd_hdr_q;          // Header echoed with readback
	reg  [1:0]  rd_ch_q;           // Channel to read back
	reg  [CH_N*16-1:0] dac_q;      // DAC registers, raw codes

	wire full_word = (cnt_q == `QDLC_FRAME_BITS);
	wire [2:0] sel = sreg_q[`QDLC_SEL_HI:`QDLC_SEL_LO];
	wire [1:0] ch  = sreg_q[`QDLC_CH_HI:`QDLC_CH_LO];
	wire wr_code   = fr_end & full_word & ~sreg_q[`QDLC_RD_BIT]
		& (sel == `QDLC_SEL_CODE);
	wire wr_ctrl   = fr_end & full_word & ~sreg_q[`QDLC_RD_BIT]
		& (sel == `QDLC_SEL_CTRL);
	wire rd_req    = fr_end & full_word & sreg_q[`QDLC_RD_BIT];

	// Shift in on falling sclk inside a frame; reload for readback
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			sreg_q    <= 24'h000000;
			cnt_q     <= 5'h00;
			rd_pend_q <= 1'b0;
			rd_hdr_q  <= 8'h00;
			rd_ch_q   <= 2'h0;
		end
		else
		begin
			if (fr_start)
				cnt_q <= 5'h00;
			else if (!frame_n && sclk_fall)
			begin
				sreg_q <= {sreg_q[22:0], serial_in_s};
				if (!full_word)
					cnt_q <= cnt_q + 5'h01;
			end
			// Readback data replaces the word, sent next frame
			if (rd_req)
			begin
				rd_pend_q <= 1'b1;
				rd_hdr_q  <= sreg_q[23:`QDLC_HDR_LO];
				rd_ch_q   <= ch;
			end
			else if (rd_pend_q)
			begin
				rd_pend_q <= 1'b0;
				sreg_q <= {rd_hdr_q, dac_q[rd_ch_q*16 +: 16]};
			end
		end
	end

	// ==========================================================
	// Serial output
	// ==========================================================
	// MSB shown at frame start, then one bit per rising sclk so
	// the far end sees it settled at the falling edge
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			serial_out_o <= 1'b0;
		else if (fr_start || (!frame_n && sclk_rise))
			serial_out_o <= sreg_q[23];
	end

	// ==========================================================
	// Control bits written over the link
	// ==========================================================
	reg mid_q;                     // Clear to midscale when set
	reg bip_q;                     // Bipolar output range selected

	// Clear choice lives here since no pin carries it
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			mid_q <= 1'b0;
			bip_q <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			mid_q <= sreg_q[`QDLC_CTRL_MID_BIT];
			bip_q <= sreg_q[`QDLC_CTRL_BIP_BIT];
		end
	end

	// Raw code that gives zero / mid scale in the current coding
	wire twos = bip_q & ~bin_s;
	wire [15:0] clr_code = (mid_q ^ twos) ? `QDLC_CODE_MSB
		: `QDLC_CODE_ZERO;

	// ==========================================================
	// Input and DAC registers, one set per channel
	// ==========================================================
	reg  [CH_N*16-1:0] inp_q;      // Input (pending) registers

	genvar g;
	generate
		for (g = 0; g < CH_N; g = g + 1)
		begin : g_ch
			wire hit = wr_code & (ch == g);
			// Clear beats every load, it is a level
			always @(posedge core_clk_i)
			begin
				if (!rst_b_i)
				begin
					inp_q[g*16 +: 16] <= `QDLC_CODE_ZERO;
					dac_q[g*16 +: 16] <= `QDLC_CODE_ZERO;
				end
				else
				begin
					if (hit)
						inp_q[g*16 +: 16] <= sreg_q[15:0];
					if (!clr_n_s)
						dac_q[g*16 +: 16] <= clr_code;
					else if (hit && !ld_n_s)
						dac_q[g*16 +: 16] <= sreg_q[15:0];
					else if (ld_fall)
						dac_q[g*16 +: 16] <= inp_q[g*16 +: 16];
				end
			end
			// Straight binary to converter; twos complement flips MSB
			always @(posedge core_clk_i)
			begin
				if (!rst_b_i)
					dac_code_o[g*16 +: 16] <= `QDLC_CODE_ZERO;
				else if (twos)
					dac_code_o[g*16 +: 16] <= dac_q[g*16 +: 16]
						^ `QDLC_CODE_MSB;
				else
					dac_code_o[g*16 +: 16] <= dac_q[g*16 +: 16];
			end
		end
	endgenerate

endmodule // qdlc_top

`default_nettype wire

// ### dv/qdlc_checker.sv
// Purpose: Timing checks on the quad DAC control pins
// Assumes: Pin effects land within a few core clocks
// Notes:   Counters hold cycles since each cause
`default_nettype none
module qdlc_checker #(parameter CH_N = 4) (
	input wire logic                 core_clk_i,
	input wire logic                 rst_b_i,
	input wire logic                 sclk_i,
	input wire logic                 sync_n_i,
	input wire logic                 serial_in_i,
	input wire logic                 serial_out_o,
	input wire logic                 load_strobe_n_i,
	input wire logic                 clear_n_i,
	input wire logic                 coding_select_i,
	input wire logic [CH_N*16-1:0]   dac_code_o
);
	timeunit 1ns; timeprecision 1ns;
	localparam logic [CH_N*16-1:0] MID = {CH_N{16'h8000}};
	logic [3:0] ocnt_q; // Since link edge
	logic [3:0] dcnt_q; // Since update cause
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ==========================================================
	// Cause counters, saturating so old causes fade
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i || $rose(sclk_i) || $changed(sync_n_i))
			ocnt_q <= 4'h0;
		else if (!(&ocnt_q))
			ocnt_q <= ocnt_q + 4'h1;
		if (!rst_b_i || $rose(sync_n_i) || $fell(load_strobe_n_i) ||
			!clear_n_i || $changed(coding_select_i))
			dcnt_q <= 4'h0;
		else if (!(&dcnt_q))
			dcnt_q <= dcnt_q + 4'h1;
	end
	// ==========================================================
	// Assertions
	AST_CLR_HOLD: assert property (!clear_n_i [*6] |->
		dac_code_o == '0 || dac_code_o == MID) else $error("clear code");
	AST_CLR_FAST: assert property ($fell(clear_n_i) |-> ##[1:6]
		(dac_code_o == '0 || dac_code_o == MID)) else $error("clear late");
	AST_OUT_IDLE: assert property (sync_n_i [*8] |->
		$stable(serial_out_o)) else $error("out moved idle");
	AST_OUT_EDGE: assert property ($changed(serial_out_o) |->
		ocnt_q < 4'h6) else $error("out moved no edge");
	AST_DAC_CAUSE: assert property ($changed(dac_code_o) |->
		dcnt_q < 4'h7) else $error("code moved no cause");
	AST_LOAD_HOLD: assert property ($rose(sync_n_i) && load_strobe_n_i
		&& clear_n_i |-> ##1 $stable(dac_code_o) [*6])
		else $error("held code moved");
	AST_ONE_STEP: assert property ($changed(dac_code_o) && clear_n_i
		|=> $stable(dac_code_o) [*3]) else $error("split update");
	AST_FRAME_HOLD: assert property ((!sync_n_i && load_strobe_n_i &&
		clear_n_i) [*8] |-> $stable(dac_code_o)) else $error("mid frame");
	cover property ($fell(load_strobe_n_i) && clear_n_i);
	cover property (!clear_n_i [*6]);
	cover property ($rose(sync_n_i) && !load_strobe_n_i);
endmodule // qdlc_checker
bind qdlc_top qdlc_checker #(.CH_N(CH_N)) u_chk (
	.core_clk_i      (core_clk_i),
	.rst_b_i         (rst_b_i),
	.sclk_i          (sclk_i),
	.sync_n_i        (sync_n_i),
	.serial_in_i     (serial_in_i),
	.serial_out_o    (serial_out_o),
	.load_strobe_n_i (load_strobe_n_i),
	.clear_n_i       (clear_n_i),
	.coding_select_i (coding_select_i),
	.dac_code_o      (dac_code_o)
);
`default_nettype wire

// ### dv/qdlc_host.sv
// Purpose: Host serial controller model
// Assumes: Link period 320 ns, clock idles high
// Notes:   Line released after frame shows inverse bit
`default_nettype none
module qdlc_host (
	output var logic sclk_o,
	output var logic sync_n_o,
	output var logic sdi_o,
	input wire logic sdo_i
);
	timeunit 1ns; timeprecision 1ns;
	initial {sclk_o, sync_n_o, sdi_o} = 3'h6;
	// Frame of n bits, MSB first; r gets serial_out bits
	task automatic xfer(input logic [23:0] w, input int n,
		output logic [23:0] r);
		r = 24'h0;
		sync_n_o = 1'b0;
		#160;
		for (int i = 23; i > 23 - n; i--)
		begin
			#80 sdi_o = w[i];
			#80 r[i] = sdo_i;
			sclk_o = 1'b0;
			#160 sclk_o = 1'b1;
		end
		#160 sync_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#640;
	endtask
endmodule // qdlc_host
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: Self-checking bench for quad DAC load and clear
// Assumes: Core clock 40 ns, link period 320 ns
// Notes:   Codes drawn from a fixed seed
`default_nettype none
module tb_top;
	timeunit 1ns; timeprecision 1ns;
	logic clk = 1'b0, rst_b = 1'b0, load_n = 1'b0, clr_n = 1'b1;
	logic cs = 1'b1, bip = 1'b0, sclk, sync_n, sdi, serial_out;
	logic [63:0] dac, old;
	logic [23:0] r;
	logic [15:0] d [4];
	integer seed = 32'h219d;
	int num_errors = 0, total_checks = 0;
	initial forever #20 clk = ~clk;
	qdlc_top DUT (.core_clk_i(clk), .rst_b_i(rst_b), .sclk_i(sclk),
		.sync_n_i(sync_n), .serial_in_i(sdi), .serial_out_o(serial_out),
		.load_strobe_n_i(load_n), .clear_n_i(clr_n),
		.coding_select_i(cs), .dac_code_o(dac));
	qdlc_host host (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi),
		.sdo_i(serial_out));
	task automatic chk(input logic [63:0] seen, exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Straight binary seen by converter; twos complement flips MSB
	function automatic logic [15:0] conv(input logic [15:0] c);
		return c ^ {bip & ~cs, 15'h0};
	endfunction
	function automatic logic [63:0] exp_dac();
		return {conv(d[3]), conv(d[2]), conv(d[1]), conv(d[0])};
	endfunction
	task automatic wr(input logic [2:0] sel, input logic [15:0] v,
		input logic [1:0] ch);
		host.xfer({1'b0, sel, 2'h0, ch, v}, 24, r);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#1ms;
		num_errors++;
		complete_run();
	end
	initial
	begin
		// Untouched channels read zero, as after reset
		for (int c = 0; c < 4; c++)
			d[c] = 16'h0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		for (int c = 0; c < 4; c++)
		begin
			d[c] = 16'($random(seed));
			wr(3'h0, d[c], c[1:0]);
			chk(dac, exp_dac(), "direct");
		end
		$display("direct done");
		load_n = 1'b1;
		old = exp_dac();
		for (int c = 0; c < 4; c++)
		begin
			d[c] = 16'($random(seed));
			wr(3'h0, d[c], c[1:0]);
		end
		chk(dac, old, "held");
		load_n = 1'b0;
		repeat (8) @(negedge clk);
		chk(dac, exp_dac(), "loaded");
		// Two short frames leave a valid ch0 write in the last 24 bits,
		// with load low, so taking one would show at once
		repeat (2) host.xfer(24'h0fff00, 20, r);
		chk(dac, exp_dac(), "short");
		$display("load done");
		host.xfer(24'h820000, 24, r);
		wr(3'h1, 16'h0003, 2'h0);
		bip = 1'b1;
		chk(r, {8'h82, d[2]}, "readback");
		wr(3'h0, d[0], 2'h0);
		chk(r, 24'h100003, "daisy");
		$display("serial out done");
		for (int k = 0; k < 2; k++)
		begin
			@(negedge clk) cs = k[0];
			d[1] = 16'($random(seed));
			wr(3'h0, d[1], 2'h1);
			chk(dac, exp_dac(), "coding");
		end
		$display("coding done");
		// Offset binary first, then coding_select low: twos complement for the midscale clear only
		for (int m = 1; m >= 0; m--)
		begin
			for (int k = 1; k >= 0; k--)
			begin
				cs = m[0];
				wr(3'h1, {14'h0, k[0], k[0]}, 2'h0);
				clr_n = 1'b0;
				repeat (8) @(negedge clk);
				chk(dac, {4{k[0], 15'h0}}, "clear");
				clr_n = 1'b1;
				repeat (8) @(negedge clk);
			end
		end
		$display("clear done");
		// Unipolar range must ignore a low coding_select
		bip = 1'b0;
		for (int c = 0; c < 4; c++)
			d[c] = 16'h0;
		d[3] = 16'($random(seed));
		wr(3'h0, d[3], 2'h3);
		chk(dac, exp_dac(), "unipolar");
		$display("unipolar done");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
